// ==== dim_pkg.sv ====
package dim_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ADIM = 8'h04;
    localparam logic [7:0] ADDR_CAL = 8'h08;
    localparam logic [7:0] ADDR_CALVAL = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam int CTRL_IDLE = 0;
    localparam int CTRL_ENCAL = 1;
    localparam int CAL_START = 0;
    localparam int CAL_DONE = 1;
    localparam int ST_GATE = 0;
    localparam int ST_LIMP = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_MODE_LSB = 4;
    localparam int MODE_W = 2;
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [7:0] ADIM_RST = 8'hFF;
    localparam logic [7:0] CALVAL_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_HZ = 10_000_000;
    localparam int CAL_TIME_US = 200;
    localparam int CAL_CYCLES = CAL_TIME_US * (CLK_HZ / 1_000_000);
endpackage : dim_pkg

// ==== cal_if.sv ====
`timescale 1ns/1ps
interface cal_if;
    logic start;
    logic busy;
    logic done;
    logic [7:0] result;
    modport ctrl (output start, input busy, input done, input result);
    modport engine (input start, output busy, output done, output result);
endinterface : cal_if

// ==== cal_engine.sv ====
`timescale 1ns/1ps
module cal_engine #(
    parameter int CYCLES = dim_pkg::CAL_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] offset_meas,
    cal_if.engine cal
);
    logic [15:0] cnt_r;
    logic busy_r;
    logic done_r;
    logic [7:0] result_r;
    wire logic last = (cnt_r == 16'(CYCLES - 1));

    // Routine runs for the fixed duration, then latches the measurement
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 16'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            result_r <= 8'h00;
        end else begin
            done_r <= busy_r && last;
            if (cal.start && !busy_r) begin
                busy_r <= 1'b1;
                cnt_r <= 16'h0000;
            end else if (busy_r) begin
                cnt_r <= cnt_r + 16'h0001;
                if (last) begin
                    busy_r <= 1'b0;
                    result_r <= offset_meas;
                end
            end
        end
    end

    assign cal.busy = busy_r;
    assign cal.done = done_r;
    assign cal.result = result_r;
endmodule : cal_engine

// ==== dimming_control.sv ====
// Behaviour
// - Gate drivers enabled while dimming PWM input high, disabled while low.
// - Mode readback holds mode seen while PWM input was last high.
// - Outside limp home, analog level comes from 8-bit serial dimming field.
// - Limp home input high puts device into limp home.
// - No switching in limp home unless PWM and enable inputs both high.
// - Limp level pin used only in limp home, else serial field.
// - Routine runs about 200 us then sets calibration done flag.
// - With enable high, routine result applied and read back.
// - With enable low, written value applied and read; start ignored.
// - Gate drivers off on internal or external supply undervoltage.
// - In limp home internal supply undervoltage does not stop switching.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module dimming_control #(
    parameter int CAL_CYCLES = dim_pkg::CAL_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic dimming_pwm_input,
    input wire logic enable_undervoltage_input,
    input wire logic limp_home_input,
    input wire logic internal_gate_supply_uv,
    input wire logic external_gate_supply_uv,
    input wire logic [7:0] limp_level_pin,
    input wire logic [1:0] regulation_mode,
    input wire logic [7:0] offset_meas,
    output logic gate_drive_en,
    output logic [7:0] dimming_level,
    output logic [7:0] calibration_value_applied
);
    cal_if cal ();

    cal_engine #(.CYCLES(CAL_CYCLES)) u_cal (
        .aclk(aclk),
        .aresetn(aresetn),
        .offset_meas(offset_meas),
        .cal(cal)
    );

    logic idle_control_bit_r;
    logic calibration_enable_r;
    logic [7:0] analog_dimming_level_r;
    logic [7:0] calibration_value_r;
    logic calibration_done_flag_r;
    logic [1:0] mode_hold_r;
    logic gate_r;
    logic [7:0] level_r;
    logic [7:0] calapp_r;

    // AXI write side: address and data taken in either order
    logic aw_full_r;
    logic w_full_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    wire logic wr_go = aw_full_r && w_full_r && !bvalid_r;
    wire logic wr_ctrl = wr_go && (aw_addr_r == dim_pkg::ADDR_CTRL) && w_strb_r[0];
    wire logic wr_adim = wr_go && (aw_addr_r == dim_pkg::ADDR_ADIM) && w_strb_r[0];
    wire logic wr_cal = wr_go && (aw_addr_r == dim_pkg::ADDR_CAL) && w_strb_r[0];
    wire logic wr_calval = wr_go && (aw_addr_r == dim_pkg::ADDR_CALVAL) && w_strb_r[0];
    wire logic wr_hit = (aw_addr_r == dim_pkg::ADDR_CTRL) || (aw_addr_r == dim_pkg::ADDR_ADIM)
        || (aw_addr_r == dim_pkg::ADDR_CAL) || (aw_addr_r == dim_pkg::ADDR_CALVAL)
        || (aw_addr_r == dim_pkg::ADDR_STAT);

    assign s_axi_awready = !aw_full_r;
    assign s_axi_wready = !w_full_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= dim_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take) begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? dim_pkg::RESP_OKAY : dim_pkg::RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Calibration start is ignored without enable or while running
    wire logic start_req = wr_cal && w_data_r[dim_pkg::CAL_START];
    wire logic start_ok = start_req && calibration_enable_r && !cal.busy;
    assign cal.start = start_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_control_bit_r <= 1'b0;
            calibration_enable_r <= 1'b0;
            analog_dimming_level_r <= dim_pkg::ADIM_RST;
            calibration_value_r <= dim_pkg::CALVAL_RST;
        end else begin
            if (wr_ctrl) begin
                idle_control_bit_r <= w_data_r[dim_pkg::CTRL_IDLE];
                calibration_enable_r <= w_data_r[dim_pkg::CTRL_ENCAL];
            end
            if (wr_adim) begin
                analog_dimming_level_r <= w_data_r[7:0];
            end
            if (wr_calval) begin
                calibration_value_r <= w_data_r[7:0];
            end
        end
    end

    // Done flag: completion wins over the start clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            calibration_done_flag_r <= 1'b0;
        end else if (cal.done) begin
            calibration_done_flag_r <= 1'b1;
        end else if (start_ok) begin
            calibration_done_flag_r <= 1'b0;
        end
    end

    // Mode readback freezes while PWM low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_hold_r <= dim_pkg::MODE_NONE;
        end else if (dimming_pwm_input) begin
            mode_hold_r <= regulation_mode;
        end
    end

    // Gate enable and level selection
    wire logic limp = limp_home_input;
    wire logic uv_int_block = internal_gate_supply_uv && !limp;
    wire logic uv_block = uv_int_block || external_gate_supply_uv;
    wire logic gate_nxt = dimming_pwm_input && enable_undervoltage_input
        && !uv_block && (limp || !idle_control_bit_r);
    wire logic [7:0] level_nxt = limp ? limp_level_pin : analog_dimming_level_r;
    wire logic [7:0] calapp_nxt = calibration_enable_r ? cal.result : calibration_value_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_r <= 1'b0;
            level_r <= 8'h00;
            calapp_r <= dim_pkg::CALVAL_RST;
        end else begin
            gate_r <= gate_nxt;
            level_r <= level_nxt;
            calapp_r <= calapp_nxt;
        end
    end

    assign gate_drive_en = gate_r;
    assign dimming_level = level_r;
    assign calibration_value_applied = calapp_r;

    // AXI read side
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    wire logic [7:0] ar_addr = {s_axi_araddr[7:2], 2'b00};
    wire logic ar_take = s_axi_arvalid && s_axi_arready;
    wire logic [31:0] rd_ctrl = {30'h0, calibration_enable_r, idle_control_bit_r};
    wire logic [31:0] rd_adim = {24'h0, analog_dimming_level_r};
    wire logic [31:0] rd_cal = {30'h0, calibration_done_flag_r, 1'b0};
    wire logic [31:0] rd_calval = {24'h0, calapp_nxt};
    wire logic [31:0] rd_stat = {26'h0, mode_hold_r, 1'b0, cal.busy, limp, gate_r};
    wire logic rd_hit = (ar_addr == dim_pkg::ADDR_CTRL) || (ar_addr == dim_pkg::ADDR_ADIM)
        || (ar_addr == dim_pkg::ADDR_CAL) || (ar_addr == dim_pkg::ADDR_CALVAL)
        || (ar_addr == dim_pkg::ADDR_STAT);
    wire logic [31:0] rd_mux = (ar_addr == dim_pkg::ADDR_CTRL) ? rd_ctrl
        : (ar_addr == dim_pkg::ADDR_ADIM) ? rd_adim
        : (ar_addr == dim_pkg::ADDR_CAL) ? rd_cal
        : (ar_addr == dim_pkg::ADDR_CALVAL) ? rd_calval
        : (ar_addr == dim_pkg::ADDR_STAT) ? rd_stat : 32'h00000000;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= dim_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? dim_pkg::RESP_OKAY : dim_pkg::RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Assertions
    property p_gate_pwm;
        @(posedge aclk) disable iff (!aresetn)
            !dimming_pwm_input |=> !gate_drive_en;
    endproperty
    a_gate_pwm: assert property (p_gate_pwm) else $error("gate on after pwm low");

    property p_gate_on;
        @(posedge aclk) disable iff (!aresetn)
            (dimming_pwm_input && enable_undervoltage_input && limp_home_input
             && !external_gate_supply_uv) |=> gate_drive_en;
    endproperty
    a_gate_on: assert property (p_gate_on) else $error("limp gate not on");

    property p_en_low;
        @(posedge aclk) disable iff (!aresetn)
            !enable_undervoltage_input |=> !gate_drive_en;
    endproperty
    a_en_low: assert property (p_en_low) else $error("gate on with enable low");

    property p_mode_hold;
        @(posedge aclk) disable iff (!aresetn)
            !dimming_pwm_input |=> mode_hold_r == $past(mode_hold_r);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed in pwm low");

    property p_level;
        @(posedge aclk) disable iff (!aresetn)
            1'b1 |=> dimming_level == ($past(limp_home_input) ? $past(limp_level_pin)
                : $past(analog_dimming_level_r));
    endproperty
    a_level: assert property (p_level) else $error("wrong dimming source");

    property p_ext_uv;
        @(posedge aclk) disable iff (!aresetn)
            external_gate_supply_uv |=> !gate_drive_en;
    endproperty
    a_ext_uv: assert property (p_ext_uv) else $error("gate on in ext uv");

    property p_int_uv;
        @(posedge aclk) disable iff (!aresetn)
            (internal_gate_supply_uv && !limp_home_input) |=> !gate_drive_en;
    endproperty
    a_int_uv: assert property (p_int_uv) else $error("gate on in int uv");

    property p_no_start;
        @(posedge aclk) disable iff (!aresetn)
            (start_req && !calibration_enable_r && !cal.busy) |=> !cal.busy;
    endproperty
    a_no_start: assert property (p_no_start) else $error("start without enable");

    property p_clear;
        @(posedge aclk) disable iff (!aresetn)
            (start_ok && !cal.done) |=> !calibration_done_flag_r;
    endproperty
    a_clear: assert property (p_clear) else $error("done not cleared");

    property p_done_time;
        @(posedge aclk) disable iff (!aresetn)
            (start_ok && !cal.done) |=> !calibration_done_flag_r [*8];
    endproperty
    a_done_time: assert property (p_done_time) else $error("done too early");

    c_cal: cover property (@(posedge aclk) disable iff (!aresetn) cal.done);
    c_limp: cover property (@(posedge aclk) disable iff (!aresetn) limp_home_input && gate_drive_en);
    c_pwm: cover property (@(posedge aclk) disable iff (!aresetn) $fell(gate_drive_en));
endmodule : dimming_control

// ==== host_pins.sv ====
`timescale 1ns/1ps
module host_pins (
    input wire logic pwm_req,
    input wire logic en_req,
    input wire logic limp_req,
    input wire logic cal_run,
    output logic dimming_pwm_input,
    output logic enable_undervoltage_input,
    output logic limp_home_input
);
    // Stops by enable low, never by a long PWM low
    assign enable_undervoltage_input = en_req;
    // PWM held low for the whole calibration run
    assign dimming_pwm_input = pwm_req & !cal_run;
    assign limp_home_input = limp_req;
endmodule : host_pins

// ==== tb_dimming_control.sv ====
`timescale 1ns/1ps
module tb_dimming_control;
    localparam int CYC = 20;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pwm_req, en_req, limp_req, cal_run;
    logic pwm, en, limp, iuv, euv, gate;
    logic [31:0] awaddr, wdata, araddr, rdata, rnd, d;
    logic [1:0] bresp, rresp, mode, r;
    logic [3:0] wstrb;
    logic [7:0] limp_lvl, offs, dim_lvl, cal_app;
    int error_cnt, tests_run, i, n;

    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end

    dimming_control #(.CAL_CYCLES(CYC)) dimming_control_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .dimming_pwm_input(pwm), .enable_undervoltage_input(en), .limp_home_input(limp),
        .internal_gate_supply_uv(iuv), .external_gate_supply_uv(euv),
        .limp_level_pin(limp_lvl), .regulation_mode(mode), .offset_meas(offs),
        .gate_drive_en(gate), .dimming_level(dim_lvl), .calibration_value_applied(cal_app));

    host_pins host_pins_inst (.pwm_req(pwm_req), .en_req(en_req), .limp_req(limp_req),
        .cal_run(cal_run), .dimming_pwm_input(pwm), .enable_undervoltage_input(en),
        .limp_home_input(limp));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[31] ? ((s << 1) ^ 32'h04C11DB7) : (s << 1);
    endfunction : lfsr

    function automatic logic gate_exp(input logic p, e, l, iu, eu, idl);
        return p & e & !(eu | (iu & !l)) & (l | !idl);
    endfunction : gate_exp

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // Handshakes sampled at the falling edge, acted on at the next rising edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
        logic ah, wh, bh;
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= dt;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid & bready;
            rs = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'h0;
            if (wh) wvalid <= 1'h0;
            if (bh) break;
        end
        bready <= 1'h0;
        if (n == 50) begin
            error_cnt++;
            print_verdict();
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
        logic ah, rh;
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            ah = arvalid & arready;
            rh = rvalid & rready;
            dt = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'h0;
            if (rh) break;
        end
        rready <= 1'h0;
        if (n == 50) begin
            error_cnt++;
            print_verdict();
        end
    endtask : axi_rd

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
        axi_rd(a, d, r);
        chk(nm, d & m, e);
    endtask : rd_chk

    task automatic gate_run(input logic idl);
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            rnd = lfsr(rnd);
            pwm_req <= rnd[0] | rnd[1];
            en_req <= rnd[2] | rnd[3];
            limp_req <= rnd[4];
            iuv <= rnd[5] & rnd[6];
            euv <= rnd[7] & rnd[8];
            @(posedge aclk);
            @(negedge aclk);
            chk("gate", gate, gate_exp(pwm, en, limp, iuv, euv, idl));
        end
    endtask : gate_run

    initial begin
        rnd = 32'h35EA20CC;
        aresetn = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready, iuv, euv} = '0;
        {pwm_req, en_req, limp_req, cal_run} = '0;
        {awaddr, wdata, araddr} = '0;
        {limp_lvl, offs, mode} = '0;
        wstrb = 4'hF;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rd_chk("ctrl_rst", dim_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
        rd_chk("adim_rst", dim_pkg::ADDR_ADIM, 32'hFF, {24'h0, dim_pkg::ADIM_RST});
        rd_chk("calval_rst", dim_pkg::ADDR_CALVAL, 32'hFF, {24'h0, dim_pkg::CALVAL_RST});
        gate_run(1'h0);
        axi_wr(dim_pkg::ADDR_CTRL, 32'h1 << dim_pkg::CTRL_IDLE, r);
        gate_run(1'h1);
        axi_wr(dim_pkg::ADDR_CTRL, 32'h0, r);
        for (i = 0; i < 8; i++) begin
            @(posedge aclk);
            rnd = lfsr(rnd);
            if (i < 2) rnd[7:0] = i[0] ? 8'h00 : 8'hFF;
            limp_req <= i[0];
            limp_lvl <= rnd[15:8];
            axi_wr(dim_pkg::ADDR_ADIM, {24'h0, rnd[7:0]}, r);
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            chk("dim_lvl", dim_lvl, i[0] ? rnd[15:8] : rnd[7:0]);
        end
        rd_chk("limp_st", dim_pkg::ADDR_STAT, 32'h2, 32'h2);
        wstrb <= 4'h0;
        axi_wr(dim_pkg::ADDR_ADIM, 32'h0, r);
        wstrb <= 4'hF;
        chk("strb_resp", {30'h0, r}, {30'h0, dim_pkg::RESP_OKAY});
        rd_chk("adim_strb", dim_pkg::ADDR_ADIM, 32'hFF, {24'h0, rnd[7:0]});
        limp_req <= 1'h0;
        pwm_req <= 1'h1;
        en_req <= 1'h1;
        mode <= 2'h2;
        repeat (3) @(posedge aclk);
        pwm_req <= 1'h0;
        mode <= 2'h1;
        rd_chk("mode_hold", dim_pkg::ADDR_STAT, 32'h30, 32'h20);
        rnd = lfsr(rnd);
        axi_wr(dim_pkg::ADDR_CALVAL, {24'h0, rnd[7:0]}, r);
        rd_chk("calval_wr", dim_pkg::ADDR_CALVAL, 32'hFF, {24'h0, rnd[7:0]});
        chk("cal_app_wr", cal_app, rnd[7:0]);
        axi_wr(dim_pkg::ADDR_CAL, 32'h1, r);
        repeat (CYC + 10) @(posedge aclk);
        rd_chk("no_start", dim_pkg::ADDR_CAL, 32'h2, 32'h0);
        cal_run <= 1'h1;
        axi_wr(dim_pkg::ADDR_CTRL, 32'h1 << dim_pkg::CTRL_ENCAL, r);
        for (i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            offs <= rnd[7:0];
            axi_wr(dim_pkg::ADDR_CAL, 32'h1, r);
            rd_chk("done_clr", dim_pkg::ADDR_CAL, 32'h2, 32'h0);
            for (int k = 0; k < 60 && d[dim_pkg::CAL_DONE] !== 1'h1; k++) begin
                axi_rd(dim_pkg::ADDR_CAL, d, r);
            end
            chk("done", d[dim_pkg::CAL_DONE], 32'h1);
            rd_chk("cal_res", dim_pkg::ADDR_CALVAL, 32'hFF, {24'h0, rnd[7:0]});
            chk("cal_app_res", cal_app, rnd[7:0]);
        end
        cal_run <= 1'h0;
        en_req <= 1'h0;
        axi_wr(8'h24, 32'h1, r);
        chk("wr_unmapped", {30'h0, r}, {30'h0, dim_pkg::RESP_SLVERR});
        axi_rd(8'h20, d, r);
        chk("rd_unmapped", {30'h0, r}, {30'h0, dim_pkg::RESP_SLVERR});
        print_verdict();
    end
endmodule : tb_dimming_control
